// ===== hbd_bus_if.sv
// Purpose: pins between the host bus port and its controller
// Assumes: both ends on the same clock
// Notes: shared pins are resolved here from the two output enables
`timescale 1ns/1ps
interface hbd_bus_if;
   logic [15:0] dev_d_o, dev_d_oe, host_d_o, host_d_oe;
   logic [15:0] dev_a_o, dev_a_oe, host_a_o, host_a_oe;
   logic [15:0] d, a;
   logic addr_latch_en_low, addr_latch_en_high;
   logic read_strobe_n, write_strobe_n, upper_byte_en_n;
   logic mem_select0_n, mem_select1_n, periph_select_n, periph_select_hi;
   logic ram_collision_n, rx_dma_request, rx_dma_ack_n, tx_dma_request, tx_dma_ack_n;
   logic irq_out_a, irq_out_b;
   logic muxed_bus_strap, bus_style_strap, strobe_polarity_strap, width_strap;
   logic byte_order_strap, high_rate_strap, rate_strap;

   assign d = (dev_d_o & dev_d_oe) | (host_d_o & host_d_oe & ~dev_d_oe);
   assign a = (dev_a_o & dev_a_oe) | (host_a_o & host_a_oe & ~dev_a_oe);

   modport dev (
      input d, a, addr_latch_en_low, addr_latch_en_high, read_strobe_n, write_strobe_n,
      input upper_byte_en_n, mem_select0_n, mem_select1_n, periph_select_n, periph_select_hi,
      input rx_dma_ack_n, tx_dma_ack_n, muxed_bus_strap, bus_style_strap, strobe_polarity_strap,
      input width_strap, byte_order_strap, high_rate_strap, rate_strap,
      output dev_d_o, dev_d_oe, dev_a_o, dev_a_oe, ram_collision_n, rx_dma_request,
      output tx_dma_request, irq_out_a, irq_out_b
   );
   modport host (
      input d, ram_collision_n, rx_dma_request, tx_dma_request, irq_out_a, irq_out_b,
      output host_d_o, host_d_oe, host_a_o, host_a_oe, addr_latch_en_low, addr_latch_en_high,
      output read_strobe_n, write_strobe_n, upper_byte_en_n, mem_select0_n, mem_select1_n,
      output periph_select_n, periph_select_hi, rx_dma_ack_n, tx_dma_ack_n,
      output muxed_bus_strap, bus_style_strap, strobe_polarity_strap, width_strap,
      output byte_order_strap, high_rate_strap, rate_strap
   );
endinterface

// ===== hbd_dev.sv
// Purpose: device end of the parallel host port with RAM, FIFOs and irq pins
// Assumes: bus pins come from logic on the same clock; straps held static
// Notes: an access is acted on at the first cycle its strobe is active
// Functional notes
// - 8-bit uses D7-0, 16-bit all lines
// - muxed strap takes address from data lines
// - latch enable high transparent, low holds
// - system ties latch enables high unmuxed
// - address pins input, or latch output muxed
// - separate style: read/write strobes active low
// - data-strobe style: polarity strap sets level
// - data-strobe style: write pin selects direction
// - style strap picks strobe style
// - width strap picks 8 or 16 bits
// - upper lane only with upper enable low
// - byte order strap maps address bit zero
// - RAM needs both memory selects low
// - registers need both peripheral selects active
// - collision output on same RAM word
// - rx request drops at last word read
// - rx acknowledge reads FIFO regardless of decode
// - tx request drops at last write
// - tx acknowledge writes FIFO regardless of decode
// - two irq outputs, programmable source, polarity
// - baud straps set rate, high strap legacy
// - software may override low baud strap
//
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/1ps
module hbd_dev (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // host pins
   hbd_bus_if.dev bus,
   // telegram side RAM port
   input wire logic int_ram_en,
   input wire logic int_ram_we,
   input wire logic [hbd_pkg::RAM_AW-1:0] int_ram_addr,
   input wire logic [15:0] int_ram_wdata,
   output logic [15:0] int_ram_rdata,
   // telegram side FIFO ports
   input wire logic rx_push,
   input wire logic [15:0] rx_push_data,
   output logic rx_push_ready,
   input wire logic tx_pop,
   output logic [15:0] tx_pop_data,
   output logic tx_pop_valid,
   // misc
   input wire logic irq_event,
   output logic [1:0] baud_sel,
   output logic legacy_mode
);
   import hbd_pkg::*;

   typedef struct packed {
      logic [15:0] lat;
      logic act;
      logic rd;
      logic pend;
      logic lane1;
      logic upper;
      logic sel;
      hbd_tgt_t kind;
      logic [RAM_AW-1:0] word;
      logic [15:0] rdata;
      logic coll;
      logic [7:0][15:0] rxm;
      logic [2:0] rxw, rxr;
      logic [3:0] rxc;
      logic [7:0][15:0] txm;
      logic [2:0] txw, txr;
      logic [3:0] txc;
      logic [15:0] irq_cfg;
      logic [1:0] baud_cfg;
      logic irq_a, irq_b;
      logic [1:0] baud;
   } hbd_dev_st_t;

   hbd_dev_st_t s_reg, s_next;
   logic [15:0] ram [RAM_DEPTH];
   logic [15:0] ram_hq;
   logic [15:0] ab, w_word, rd_val;
   logic ds, rd, wr, act, start, upper_c, lane1_c, sel_c, rx_pop, tx_push, rx_in, tx_out;
   logic ram_we_hi, ram_we_lo, regacc;
   logic [3:0] src;
   hbd_tgt_t kind_c;

   assign ab = bus.muxed_bus_strap ?
               {bus.addr_latch_en_high ? bus.d[15:8] : s_reg.lat[15:8],
                bus.addr_latch_en_low ? bus.d[7:0] : s_reg.lat[7:0]} : bus.a;
   assign bus.dev_a_o = ab;
   assign bus.dev_a_oe = {16{bus.muxed_bus_strap}};

   assign ds = bus.strobe_polarity_strap ? bus.read_strobe_n : ~bus.read_strobe_n;
   assign rd = bus.bus_style_strap ? (ds & bus.write_strobe_n) : ~bus.read_strobe_n;
   assign wr = bus.bus_style_strap ? (ds & ~bus.write_strobe_n) : ~bus.write_strobe_n;
   assign act = rd | wr;
   assign start = act & ~s_reg.act;

   assign upper_c = hbd_upper(ab[0], bus.byte_order_strap);
   assign lane1_c = bus.width_strap & ~bus.upper_byte_en_n;
   assign w_word = hbd_swap(bus.d, upper_c);

   always_comb begin
      sel_c = 1'b1;
      kind_c = TGT_RAM;
      if (~bus.rx_dma_ack_n & rd) begin
         kind_c = TGT_RX;
      end else if (~bus.tx_dma_ack_n & wr) begin
         kind_c = TGT_TX;
      end else if (~bus.mem_select0_n & ~bus.mem_select1_n) begin
         kind_c = TGT_RAM;
      end else if (~bus.periph_select_n & bus.periph_select_hi) begin
         kind_c = TGT_REG;
      end else begin
         sel_c = 1'b0;
      end
   end

   assign regacc = start & sel_c & (kind_c == TGT_REG);
   assign rx_pop = start & rd & sel_c & (s_reg.rxc != 4'h0) &
                   ((kind_c == TGT_RX) | (regacc & (ab[6:1] == REG_RX_DATA)));
   assign tx_push = start & wr & sel_c & (s_reg.txc < FIFO_FULL) &
                    ((kind_c == TGT_TX) | (regacc & (ab[6:1] == REG_TX_DATA)));
   assign rx_in = rx_push & (s_reg.rxc < FIFO_FULL);
   assign tx_out = tx_pop & (s_reg.txc != 4'h0);
   assign ram_we_hi = start & wr & sel_c & (kind_c == TGT_RAM) & (upper_c | lane1_c);
   assign ram_we_lo = start & wr & sel_c & (kind_c == TGT_RAM) & (~upper_c | lane1_c);
   assign src = {irq_event, s_reg.coll, s_reg.txc < FIFO_FULL, s_reg.rxc != 4'h0};

   always_comb begin
      case (ab[6:1])
         REG_RX_DATA: rd_val = (s_reg.rxc != 4'h0) ? s_reg.rxm[s_reg.rxr] : 16'h0000;
         REG_IRQ_CFG: rd_val = s_reg.irq_cfg;
         REG_BAUD: rd_val = {14'h0000, s_reg.baud_cfg};
         REG_STATUS: rd_val = {7'h00, s_reg.coll, s_reg.txc, s_reg.rxc};
         default: rd_val = 16'h0000;
      endcase
      if (kind_c == TGT_RX) begin
         rd_val = (s_reg.rxc != 4'h0) ? s_reg.rxm[s_reg.rxr] : 16'h0000;
      end
   end

   always_comb begin
      s_next = s_reg;
      s_next.act = act;
      s_next.pend = 1'b0;
      if (bus.muxed_bus_strap) begin
         s_next.lat = ab;
      end
      // same word collision, live decode on the start cycle
      s_next.coll = act & int_ram_en & (start ?
                    (sel_c & (kind_c == TGT_RAM) & (int_ram_addr == ab[RAM_AW:1])) :
                    (s_reg.sel & (s_reg.kind == TGT_RAM) & (int_ram_addr == s_reg.word)));
      if (s_reg.pend) begin
         s_next.rdata = hbd_swap(ram_hq, s_reg.upper);
      end
      if (start) begin
         s_next.rd = rd;
         s_next.upper = upper_c;
         s_next.lane1 = lane1_c;
         s_next.sel = sel_c;
         s_next.kind = kind_c;
         s_next.word = ab[RAM_AW:1];
         s_next.pend = sel_c & rd & (kind_c == TGT_RAM);
         s_next.rdata = hbd_swap(rd_val, upper_c);
         if (regacc & wr & (ab[6:1] == REG_IRQ_CFG)) begin
            if (upper_c | lane1_c) s_next.irq_cfg[15:8] = w_word[15:8];
            if (~upper_c | lane1_c) s_next.irq_cfg[7:0] = w_word[7:0];
         end
         if (regacc & wr & (ab[6:1] == REG_BAUD) & (~upper_c | lane1_c)) begin
            s_next.baud_cfg = w_word[1:0];
         end
      end
      if (rx_in) begin
         s_next.rxm[s_reg.rxw] = rx_push_data;
         s_next.rxw = s_reg.rxw + 3'h1;
      end
      if (rx_pop) begin
         s_next.rxr = s_reg.rxr + 3'h1;
      end
      s_next.rxc = s_reg.rxc + {3'h0, rx_in} - {3'h0, rx_pop};
      if (tx_push) begin
         s_next.txm[s_reg.txw] = w_word;
         s_next.txw = s_reg.txw + 3'h1;
      end
      if (tx_out) begin
         s_next.txr = s_reg.txr + 3'h1;
      end
      s_next.txc = s_reg.txc + {3'h0, tx_push} - {3'h0, tx_out};
      s_next.irq_a = ~((|(src & s_reg.irq_cfg[IRQ_SEL_A_LSB +: 4])) ^ s_reg.irq_cfg[IRQ_POL_A_BIT]);
      s_next.irq_b = ~((|(src & s_reg.irq_cfg[IRQ_SEL_B_LSB +: 4])) ^ s_reg.irq_cfg[IRQ_POL_B_BIT]);
      s_next.baud = {bus.high_rate_strap,
                     s_reg.baud_cfg[BAUD_OVR_EN_BIT] ? s_reg.baud_cfg[BAUD_OVR_VAL_BIT] : bus.rate_strap};
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_reg <= '0;
         s_reg.irq_cfg <= IRQ_CFG_RST;
         s_reg.baud_cfg <= BAUD_CFG_RST;
         s_reg.irq_a <= 1'b1;
         s_reg.irq_b <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   // telegram side written last so it wins a same-word write
   always_ff @(posedge clk) begin
      if (ram_we_hi) ram[ab[RAM_AW:1]][15:8] <= w_word[15:8];
      if (ram_we_lo) ram[ab[RAM_AW:1]][7:0] <= w_word[7:0];
      if (int_ram_en & int_ram_we) ram[int_ram_addr] <= int_ram_wdata;
      ram_hq <= ram[ab[RAM_AW:1]];
      int_ram_rdata <= ram[int_ram_addr];
   end

   assign bus.dev_d_o = s_reg.rdata;
   assign bus.dev_d_oe = (act & s_reg.rd & s_reg.sel & ~s_reg.pend & ~start) ?
                         {{8{s_reg.lane1}}, 8'hFF} : 16'h0000;
   assign bus.ram_collision_n = ~s_reg.coll;
   // drops as last word read starts
   assign bus.rx_dma_request = s_reg.rxc > {3'h0, rx_pop};
   assign bus.tx_dma_request = (s_reg.txc + {3'h0, tx_push}) < FIFO_FULL;
   assign bus.irq_out_a = s_reg.irq_a;
   assign bus.irq_out_b = s_reg.irq_b;
   assign rx_push_ready = s_reg.rxc < FIFO_FULL;
   assign tx_pop_valid = s_reg.txc != 4'h0;
   assign tx_pop_data = s_reg.txm[s_reg.txr];
   assign baud_sel = s_reg.baud;
   assign legacy_mode = s_reg.baud[1];
endmodule

// ===== hbd_host.sv
// Purpose: controller end that runs single bus cycles on the host port
// Assumes: software writes address and data before the command
// Notes: a command written while a cycle runs is ignored
`timescale 1ns/1ps
module hbd_host (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // host pins
   hbd_bus_if.host bus,
   // command port
   input wire logic [3:0] cpu_addr,
   input wire logic [15:0] cpu_wdata,
   input wire logic cpu_wr,
   input wire logic cpu_rd,
   output logic [15:0] cpu_rdata
);
   import hbd_pkg::*;

   typedef enum logic [2:0] {
      H_IDLE = 3'b000,
      H_ALE = 3'b001,
      H_HOLD = 3'b010,
      H_STROBE = 3'b011,
      H_END = 3'b100
   } hbd_hst_t;

   typedef struct packed {
      hbd_hst_t st;
      logic cmd_wr;
      hbd_tgt_t tgt;
      logic ube;
      logic [15:0] addr;
      logic [15:0] wdata;
      logic [15:0] rdata;
      logic [6:0] straps;
      logic [3:0] cnt;
      logic [15:0] cpu_rdata;
   } hbd_host_st_t;

   hbd_host_st_t s_reg, s_next;
   logic busy, strobe, mux;

   assign mux = s_reg.straps[STRAP_MUX];
   assign busy = (s_reg.st != H_IDLE) & (s_reg.st != H_END);
   assign strobe = s_reg.st == H_STROBE;

   always_comb begin
      s_next = s_reg;
      if (cpu_rd) begin
         case (cpu_addr)
            HR_ADDR: s_next.cpu_rdata = s_reg.addr;
            HR_WDATA: s_next.cpu_rdata = s_reg.wdata;
            HR_RDATA: s_next.cpu_rdata = s_reg.rdata;
            HR_STATUS: s_next.cpu_rdata = {10'h000, bus.irq_out_b, bus.irq_out_a, ~bus.ram_collision_n,
                                           bus.tx_dma_request, bus.rx_dma_request, s_reg.st != H_IDLE};
            HR_STRAPS: s_next.cpu_rdata = {9'h000, s_reg.straps};
            default: s_next.cpu_rdata = 16'h0000;
         endcase
      end
      if (cpu_wr) begin
         if (cpu_addr == HR_ADDR) s_next.addr = cpu_wdata;
         if (cpu_addr == HR_WDATA) s_next.wdata = cpu_wdata;
         if ((cpu_addr == HR_STRAPS) & (s_reg.st == H_IDLE)) s_next.straps = cpu_wdata[6:0];
      end
      unique case (s_reg.st)
         H_IDLE: begin
            if (cpu_wr & (cpu_addr == HR_CMD)) begin
               s_next.cmd_wr = cpu_wdata[CMD_WRITE_BIT];
               s_next.tgt = hbd_tgt_t'(cpu_wdata[CMD_TGT_LSB +: 2]);
               s_next.ube = cpu_wdata[CMD_UBE_BIT];
               s_next.st = mux ? H_ALE : H_STROBE;
               s_next.cnt = STROBE_CYC;
            end
         end
         H_ALE: s_next.st = H_HOLD;
         H_HOLD: s_next.st = H_STROBE;
         H_STROBE: begin
            s_next.cnt = s_reg.cnt - 4'h1;
            if (s_reg.cnt == 4'h1) begin
               if (~s_reg.cmd_wr) s_next.rdata = bus.d;
               s_next.st = H_END;
            end
         end
         H_END: s_next.st = H_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_reg <= '0;
         s_reg.straps <= STRAPS_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   assign cpu_rdata = s_reg.cpu_rdata;
   // address phase, latches tied high unmuxed
   assign bus.addr_latch_en_low = ~mux | (s_reg.st == H_ALE);
   assign bus.addr_latch_en_high = ~mux | (s_reg.st == H_ALE);
   assign bus.host_a_o = s_reg.addr;
   assign bus.host_a_oe = {16{~mux}};
   assign bus.host_d_o = strobe ? s_reg.wdata : s_reg.addr;
   assign bus.host_d_oe = (mux & ((s_reg.st == H_ALE) | (s_reg.st == H_HOLD))) ? 16'hFFFF :
                          (strobe & s_reg.cmd_wr) ? {{8{s_reg.straps[STRAP_WIDTH]}}, 8'hFF} : 16'h0000;
   assign bus.read_strobe_n = s_reg.straps[STRAP_STYLE] ?
                              (strobe ^ ~s_reg.straps[STRAP_POL]) : ~(strobe & ~s_reg.cmd_wr);
   assign bus.write_strobe_n = s_reg.straps[STRAP_STYLE] ? ~(busy & s_reg.cmd_wr) : ~(strobe & s_reg.cmd_wr);
   assign bus.upper_byte_en_n = ~(busy & s_reg.ube);
   assign bus.mem_select0_n = ~(busy & (s_reg.tgt == TGT_RAM));
   assign bus.mem_select1_n = ~(busy & (s_reg.tgt == TGT_RAM));
   assign bus.periph_select_n = ~(busy & (s_reg.tgt == TGT_REG));
   assign bus.periph_select_hi = busy & (s_reg.tgt == TGT_REG);
   assign bus.rx_dma_ack_n = ~(busy & (s_reg.tgt == TGT_RX));
   assign bus.tx_dma_ack_n = ~(busy & (s_reg.tgt == TGT_TX));
   assign bus.muxed_bus_strap = mux;
   assign bus.bus_style_strap = s_reg.straps[STRAP_STYLE];
   assign bus.strobe_polarity_strap = s_reg.straps[STRAP_POL];
   assign bus.width_strap = s_reg.straps[STRAP_WIDTH];
   assign bus.byte_order_strap = s_reg.straps[STRAP_ORDER];
   assign bus.high_rate_strap = s_reg.straps[STRAP_HIRATE];
   assign bus.rate_strap = s_reg.straps[STRAP_RATE];
endmodule

// ===== hbd_monitor.sv
// Purpose: pin checks between the host port and its controller
// Assumes: one clock, synchronous active high reset
// Notes: sees only the interface signals
`timescale 1ns/1ps
module hbd_monitor (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // device side
   input wire logic [15:0] dev_d_oe,
   input wire logic [15:0] dev_a_oe,
   input wire logic rx_dma_request,
   input wire logic tx_dma_request,
   // controller side
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   input wire logic upper_byte_en_n,
   input wire logic rx_dma_ack_n,
   input wire logic tx_dma_ack_n,
   input wire logic muxed_bus_strap,
   input wire logic bus_style_strap,
   input wire logic strobe_polarity_strap,
   input wire logic width_strap
);
   import hbd_pkg::*;
   logic ds_on;
   logic rd_act;
   logic wr_act;
   assign ds_on = strobe_polarity_strap ? read_strobe_n : !read_strobe_n;
   assign rd_act = bus_style_strap ? ds_on && write_strobe_n : !read_strobe_n;
   assign wr_act = bus_style_strap ? ds_on && !write_strobe_n : !write_strobe_n;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // active strobe lasts four cycles, then drops
   sequence s_hold4(x);
      x[*4] ##1 !x;
   endsequence
   rd_len_a: assert property ($rose(rd_act) |-> s_hold4(rd_act))
      else $error("read strobe length wrong");
   wr_len_a: assert property ($rose(wr_act) |-> s_hold4(wr_act))
      else $error("write strobe length wrong");
   rx_drop_a: assert property ($fell(rx_dma_request) |-> rd_act && !$past(rd_act) && !rx_dma_ack_n)
      else $error("rx request fell outside a read start");
   tx_drop_a: assert property ($fell(tx_dma_request) |-> wr_act && !$past(wr_act) && !tx_dma_ack_n)
      else $error("tx request fell outside a write start");
   oe_read_a: assert property (|dev_d_oe |-> rd_act || $past(rd_act))
      else $error("device drove data outside a read");
   lane_narrow_a: assert property (!width_strap |-> dev_d_oe[15:8] == 8'h00)
      else $error("upper lane driven in 8-bit mode");
   upper_lane_a: assert property (|dev_d_oe[15:8] |-> !upper_byte_en_n || $past(!upper_byte_en_n))
      else $error("upper lane driven without enable");
   addr_dir_a: assert property ($stable(muxed_bus_strap) |-> dev_a_oe == {16{muxed_bus_strap}})
      else $error("address pin direction wrong");
endmodule

// ===== hbd_pkg.sv
// Purpose: shared constants and types of the host bus port, both ends
// Assumes: one 100 MHz clock for both ends
// Notes: device registers are word indexed by address bits 6..1
package hbd_pkg;
   localparam int CLK_NS = 10;
   localparam int DW = 16;
   localparam int AW = 16;
   localparam int RAM_DEPTH = 2048;
   localparam int RAM_AW = 11;
   localparam int FIFO_DEPTH = 8;
   localparam logic [3:0] FIFO_FULL = 4'h8;
   // device control registers, index on address bits 6..1
   localparam logic [5:0] REG_RX_DATA = 6'h00;
   localparam logic [5:0] REG_TX_DATA = 6'h01;
   localparam logic [5:0] REG_IRQ_CFG = 6'h02;
   localparam logic [5:0] REG_BAUD = 6'h03;
   localparam logic [5:0] REG_STATUS = 6'h04;
   localparam int IRQ_SEL_A_LSB = 0;
   localparam int IRQ_SEL_B_LSB = 4;
   localparam int IRQ_POL_A_BIT = 8;
   localparam int IRQ_POL_B_BIT = 9;
   localparam logic [15:0] IRQ_CFG_RST = 16'h0000;
   localparam int BAUD_OVR_EN_BIT = 0;
   localparam int BAUD_OVR_VAL_BIT = 1;
   localparam logic [1:0] BAUD_CFG_RST = 2'h0;
   // controller command port registers
   localparam logic [3:0] HR_CMD = 4'h0;
   localparam logic [3:0] HR_ADDR = 4'h1;
   localparam logic [3:0] HR_WDATA = 4'h2;
   localparam logic [3:0] HR_RDATA = 4'h3;
   localparam logic [3:0] HR_STATUS = 4'h4;
   localparam logic [3:0] HR_STRAPS = 4'h5;
   localparam int CMD_WRITE_BIT = 0;
   localparam int CMD_TGT_LSB = 1;
   localparam int CMD_UBE_BIT = 3;
   localparam int STRAP_MUX = 0;
   localparam int STRAP_STYLE = 1;
   localparam int STRAP_POL = 2;
   localparam int STRAP_WIDTH = 3;
   localparam int STRAP_ORDER = 4;
   localparam int STRAP_HIRATE = 5;
   localparam int STRAP_RATE = 6;
   localparam logic [6:0] STRAPS_RST = 7'h08;
   localparam int STROBE_NS = 40;
   localparam logic [3:0] STROBE_CYC = 4'((STROBE_NS + CLK_NS - 1) / CLK_NS);

   typedef enum logic [1:0] {
      TGT_RAM = 2'b00,
      TGT_REG = 2'b01,
      TGT_RX = 2'b10,
      TGT_TX = 2'b11
   } hbd_tgt_t;

   // true when address bit 0 picks the upper byte of a word
   function automatic logic hbd_upper(input logic a0, input logic order);
      hbd_upper = a0 ^ order;
   endfunction

   function automatic logic [15:0] hbd_swap(input logic [15:0] w, input logic sw);
      hbd_swap = sw ? {w[7:0], w[15:8]} : w;
   endfunction
endpackage

// ===== host_bus_dma_interface_bench.sv
// Purpose: self-checking bench of both host port ends
// Assumes: controller command port drives every bus cycle
// Notes: queue and array model gives the RAM and FIFO word expected values; byte lane checks use the written word w, the other checks constants
`timescale 1ns/1ps
module host_bus_dma_interface_bench;
   import hbd_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [3:0] cpu_addr = 4'h0;
   logic [15:0] cpu_wdata = 16'h0000, rx_push_data = 16'h0000, cpu_rdata, tx_pop_data, r, w;
   logic cpu_wr = 1'b0, cpu_rd = 1'b0, int_ram_en = 1'b0, rx_push = 1'b0, tx_pop = 1'b0, irq_event = 1'b0;
   logic [10:0] int_ram_addr = 11'h000;
   logic tx_pop_valid, legacy_mode, rx_push_ready;
   logic [15:0] int_ram_rdata;
   logic coll_seen = 1'b0;
   logic [1:0] baud_sel;
   logic [15:0] ram_m [int];
   logic [15:0] tx_q[$], rx_q[$];
   int error_cnt = 0, checks = 0, wa;
   hbd_bus_if hbd_bus_if_i ();
   hbd_dev hbd_dev_i (.clk(clk), .sys_rst(sys_rst), .bus(hbd_bus_if_i), .int_ram_en(int_ram_en),
      .int_ram_we(1'b0), .int_ram_addr(int_ram_addr), .int_ram_wdata(16'h0000), .int_ram_rdata(int_ram_rdata),
      .rx_push(rx_push), .rx_push_data(rx_push_data), .rx_push_ready(rx_push_ready), .tx_pop(tx_pop),
      .tx_pop_data(tx_pop_data), .tx_pop_valid(tx_pop_valid), .irq_event(irq_event),
      .baud_sel(baud_sel), .legacy_mode(legacy_mode));
   hbd_host hbd_host_i (.clk(clk), .sys_rst(sys_rst), .bus(hbd_bus_if_i), .cpu_addr(cpu_addr),
      .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata));
   hbd_monitor hbd_monitor_i (.clk(clk), .sys_rst(sys_rst), .dev_d_oe(hbd_bus_if_i.dev_d_oe),
      .dev_a_oe(hbd_bus_if_i.dev_a_oe), .rx_dma_request(hbd_bus_if_i.rx_dma_request),
      .tx_dma_request(hbd_bus_if_i.tx_dma_request), .read_strobe_n(hbd_bus_if_i.read_strobe_n),
      .write_strobe_n(hbd_bus_if_i.write_strobe_n), .upper_byte_en_n(hbd_bus_if_i.upper_byte_en_n),
      .rx_dma_ack_n(hbd_bus_if_i.rx_dma_ack_n), .tx_dma_ack_n(hbd_bus_if_i.tx_dma_ack_n),
      .muxed_bus_strap(hbd_bus_if_i.muxed_bus_strap), .bus_style_strap(hbd_bus_if_i.bus_style_strap),
      .strobe_polarity_strap(hbd_bus_if_i.strobe_polarity_strap), .width_strap(hbd_bus_if_i.width_strap));
   initial begin
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (hbd_bus_if_i.ram_collision_n === 1'b0) coll_seen <= 1'b1;
   end
   task automatic results();
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(string n, logic [15:0] e, logic [15:0] g);
      checks++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   // one command port cycle, strobes stay until the next call
   task automatic drv(logic wr, logic rd, logic [3:0] ad, logic [15:0] dt);
      @(posedge clk);
      cpu_wr <= wr;
      cpu_rd <= rd;
      cpu_addr <= ad;
      cpu_wdata <= dt;
   endtask
   task automatic cr(logic [3:0] ad, output logic [15:0] dt);
      drv(1'b0, 1'b1, ad, 16'h0000);
      drv(1'b0, 1'b0, ad, 16'h0000);
      #1 dt = cpu_rdata;
   endtask
   task automatic strap(logic [6:0] s);
      drv(1'b1, 1'b0, HR_STRAPS, {9'h000, s});
      drv(1'b0, 1'b0, HR_CMD, 16'h0000);
   endtask
   task automatic op(logic wr, logic [1:0] t, logic [15:0] ad, logic [15:0] dt, logic ube,
         output logic [15:0] rd);
      drv(1'b1, 1'b0, HR_ADDR, ad);
      drv(1'b1, 1'b0, HR_WDATA, dt);
      drv(1'b1, 1'b0, HR_CMD, {12'h000, ube, t, wr});
      rd = 16'h0001;
      for (int i = 0; i < 60 && rd[0]; i++) cr(HR_STATUS, rd);
      if (rd[0]) begin
         error_cnt++;
         $display("CHECK FAILED bus cycle done expected 0 seen 1");
      end
      cr(HR_RDATA, rd);
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      results();
   end
   initial begin
      void'($urandom(66682));
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      for (int c = 0; c < 8; c++) begin
         strap({4'h1, c[2:0]});
         wa = $urandom_range(2047);
         w = 16'($urandom);
         ram_m[wa] = w;
         op(1'b1, TGT_RAM, 16'(wa * 2), w, 1'b1, r);
         op(1'b0, TGT_RAM, 16'(wa * 2), 16'h0000, 1'b1, r);
         chk("ram word", ram_m[wa], r);
      end
      for (int k = 0; k < 4; k++) begin
         strap({2'h0, k[1], 4'h0});
         op(1'b0, TGT_RAM, 16'(wa * 2 + k[0]), 16'h0000, 1'b0, r);
         chk("byte lane", {8'h00, (k[0] ^ k[1]) ? w[15:8] : w[7:0]}, r);
      end
      strap(7'h08);
      int_ram_addr <= 11'(wa);
      int_ram_en <= 1'b1;
      op(1'b0, TGT_RAM, 16'(wa * 2), 16'h0000, 1'b0, r);
      @(posedge clk);
      int_ram_en <= 1'b0;
      chk("upper lane off", {8'h00, w[7:0]}, r);
      chk("collision", 16'h0001, 16'(coll_seen));
      chk("telegram read", ram_m[wa], int_ram_rdata);
      for (int i = 0; i < 8; i++) begin
         tx_q.push_back(16'($urandom));
         op(1'b1, TGT_TX, 16'($urandom) & 16'hFFFE, tx_q[i], 1'b1, r);
      end
      chk("tx request full", 16'h0000, 16'(hbd_bus_if_i.tx_dma_request));
      chk("tx valid full", 16'h0001, 16'(tx_pop_valid));
      while (tx_q.size() > 0) begin
         chk("tx word", tx_q.pop_front(), tx_pop_data);
         @(posedge clk) tx_pop <= 1'b1;
         @(posedge clk) tx_pop <= 1'b0;
         #1;
      end
      chk("tx request empty", 16'h0001, 16'(hbd_bus_if_i.tx_dma_request));
      chk("tx valid empty", 16'h0000, 16'(tx_pop_valid));
      for (int i = 0; i < 2; i++) begin
         rx_q.push_back(16'($urandom));
         @(posedge clk);
         rx_push <= 1'b1;
         rx_push_data <= rx_q[i];
      end
      @(posedge clk) rx_push <= 1'b0;
      #1 chk("rx request", 16'h0001, 16'(hbd_bus_if_i.rx_dma_request));
      chk("rx push ready", 16'h0001, 16'(rx_push_ready));
      op(1'b0, TGT_REG, {9'h000, REG_STATUS, 1'b0}, 16'h0000, 1'b1, r);
      chk("reg status", 16'h0002, r);
      for (int i = 0; i < 2; i++) begin
         op(1'b0, TGT_RX, 16'($urandom) & 16'hFFFE, 16'h0000, 1'b1, r);
         chk("rx word", rx_q.pop_front(), r);
      end
      chk("rx request drained", 16'h0000, 16'(hbd_bus_if_i.rx_dma_request));
      op(1'b1, TGT_REG, {9'h000, REG_IRQ_CFG, 1'b0}, 16'h0108, 1'b1, r);
      op(1'b0, TGT_REG, {9'h000, REG_IRQ_CFG, 1'b0}, 16'h0000, 1'b1, r);
      chk("irq config", 16'h0108, r);
      @(posedge clk) irq_event <= 1'b1;
      repeat (3) @(posedge clk);
      #1 chk("irq a on", 16'h0001, 16'(hbd_bus_if_i.irq_out_a));
      chk("irq b idle", 16'h0001, 16'(hbd_bus_if_i.irq_out_b));
      @(posedge clk) irq_event <= 1'b0;
      repeat (3) @(posedge clk);
      #1 chk("irq a off", 16'h0000, 16'(hbd_bus_if_i.irq_out_a));
      strap(7'h28);
      repeat (3) @(posedge clk);
      #1 chk("legacy baud", 16'h0006, 16'({legacy_mode, baud_sel}));
      op(1'b1, TGT_REG, {9'h000, REG_BAUD, 1'b0}, 16'h0003, 1'b1, r);
      repeat (3) @(posedge clk);
      #1 chk("baud override", 16'h0007, 16'({legacy_mode, baud_sel}));
      results();
   end
endmodule
